// file: shared/adcms_defs.vh
`ifndef ADCMS_DEFS_VH
`define ADCMS_DEFS_VH
// Register byte offsets on the APB port
`define ADCMS_CTRL_OFS      8'h00
`define ADCMS_KEY_OFS       8'h04
`define ADCMS_CHSEL_OFS     8'h08
`define ADCMS_SPACE_OFS     8'h0C
`define ADCMS_LIMIT_OFS     8'h10
`define ADCMS_STAT_OFS      8'h14
`define ADCMS_IRQS_OFS      8'h18
`define ADCMS_IRQM_OFS      8'h1C
`define ADCMS_DATA_OFS      8'h20
// Control register fields
`define ADCMS_MODE_MSB      2
`define ADCMS_GO_BIT        3
`define ADCMS_HALT_BIT      4
`define ADCMS_CAL_BIT       5
`define ADCMS_SRST_BIT      6
// Limit register fields
`define ADCMS_HI_LSB        16
// Interrupt status bits
`define ADCMS_IRQ_DONE      0
`define ADCMS_IRQ_HIGH      1
`define ADCMS_IRQ_LOW       2
`define ADCMS_IRQ_END       3
// Reset values
`define ADCMS_MODE_RST      3'h0
`define ADCMS_CHSEL_RST     2'h1
`define ADCMS_SPACE_RST     8'h01
`define ADCMS_HI_RST        12'hFFF
`define ADCMS_LO_RST        12'h000
// Key that unlocks the soft reset
`define ADCMS_KEY_VAL       8'h0A
// Upper bits of the bus address, low three come from the strap
`define ADCMS_ADDR_BASE     4'h1
// Bus bytes of the general-call reset
`define ADCMS_GCALL_BYTE    8'h00
`define ADCMS_SRST_BYTE     8'h06
// SCL periods per manual-mode sample
`define ADCMS_SCL_PER_SMP   5'd18
// Timing in ns and derived clock counts
`define ADCMS_CLK_NS        10
`define ADCMS_CAL_NS        2000
`define ADCMS_CAL_CYC       ((`ADCMS_CAL_NS) / (`ADCMS_CLK_NS))
`define ADCMS_STRETCH_NS    1800
`define ADCMS_STRETCH_CYC   ((`ADCMS_STRETCH_NS + `ADCMS_CLK_NS - 1) / (`ADCMS_CLK_NS))
`define ADCMS_OSC_NS        1000
`define ADCMS_OSC_CYC       ((`ADCMS_OSC_NS) / (`ADCMS_CLK_NS))
`endif

// file: src/adcms_sync.v
`timescale 1ns/100ps
`default_nettype none
module adcms_sync #(
	parameter W = 1                         // Number of bits
) (
	input  wire         ref_clk,            // Block clock
	input  wire [W-1:0] d,                  // Asynchronous inputs
	output reg  [W-1:0] q                   // Synchronised outputs
);
	reg [W-1:0] meta_reg;                   // First stage, read only by q

	// Two flops against metastability; no reset needed on a data path
	always @(posedge ref_clk) begin
		meta_reg <= d;
		q        <= meta_reg;
	end
endmodule // adcms_sync
`default_nettype wire

// file: src/adcms_scl_pace.v
`timescale 1ns/100ps
`default_nettype none
`include "adcms_defs.vh"
module adcms_scl_pace (
	input  wire ref_clk,                    // Block clock
	input  wire rstn,                       // Synchronous reset, active low
	input  wire run,                        // Manual stream active
	input  wire scl_s,                      // Synchronised SCL level
	output reg  sample_tick,                // One pulse per sample
	output wire scl_oe_n                    // Low while holding SCL low
);
	reg       scl_d_reg;                    // SCL one cycle ago
	reg [4:0] fall_cnt_reg;                 // Falling edges in this sample
	reg [7:0] hold_cnt_reg;                 // Cycles of SCL low so far
	reg       stretch_reg;                  // Driving SCL low

	wire scl_fall = scl_d_reg & ~scl_s;     // Falling edge of SCL

	assign scl_oe_n = ~stretch_reg;

	// Count 18 SCL periods per sample, then hold SCL for the minimum low time
	always @(posedge ref_clk) begin
		if (!rstn || !run) begin
			scl_d_reg    <= 1'b1;
			fall_cnt_reg <= 5'h00;
			hold_cnt_reg <= 8'h00;
			stretch_reg  <= 1'b0;
			sample_tick  <= 1'b0;
		end else begin
			scl_d_reg   <= scl_s;
			sample_tick <= 1'b0;
			if (scl_fall) begin
				if (fall_cnt_reg == `ADCMS_SCL_PER_SMP - 5'd1) begin
					// Sample boundary: stretch starts, converter starts
					fall_cnt_reg <= 5'h00;
					sample_tick  <= 1'b1;                // R16
					stretch_reg  <= 1'b1;                // R16
					hold_cnt_reg <= 8'h00;
				end else begin
					fall_cnt_reg <= fall_cnt_reg + 5'd1;
				end
			end else if (stretch_reg) begin
				// A host low time of 1.83 us or more outlasts this hold, which starts three cycles after the pin falls, so no visible stretch
				if ({24'h0, hold_cnt_reg} == `ADCMS_STRETCH_CYC - 1)
					stretch_reg <= 1'b0;                 // R16
				else
					hold_cnt_reg <= hold_cnt_reg + 8'd1;
			end
		end
	end
endmodule // adcms_scl_pace
`default_nettype wire

// file: src/adcms_top.v
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "adcms_defs.vh"
// What this block does
// R1: Powers up in manual mode until reconfigured
// R2: Calibrate, read strap, pending output high meanwhile
// R3: General call 00h then 06h resets device
// R4: Full reset clears config, recalibrates, rereads address
// R5: Soft reset needs key, keeps window flags and key
// R6: Soft reset skips calibration and address evaluation
// R7: Calibration trigger bit runs offset calibration
// R8: Power-up selects the first input only, first sample input 0
// R9: Manual mode ignores the cycle spacing count
// R10: Modes 000b/001b convert first input on read frame
// R11: Single-input stream ends on NACK then STOP
// R12: Modes 100b/101b start on go bit plus read
// R13: Halt bit stops the scan before mode change
// R14: Any register read ends the scan
// R15: Both inputs scanned alternate first then second
// R16: 18 SCL periods per sample, stretch of 1.8us
// R17: Autonomous mode: host starts, oscillator paces rest
// R18: Autonomous mode raises alert on limit crossing
// R19: Unassigned mode codes leave device idle
module adcms_top (
	input  wire        ref_clk,           // 100 MHz clock
	input  wire        rstn,              // Synchronous reset, active low
	input  wire [7:0]  paddr,             // APB address
	input  wire        psel,              // APB select
	input  wire        penable,           // APB enable
	input  wire        pwrite,            // APB direction
	input  wire [31:0] pwdata,            // APB write data
	output reg  [31:0] prdata,            // APB read data
	output wire        pready,            // APB ready
	output reg         pslverr,           // APB error on unmapped address
	input  wire        scl_in,            // SCL pin level
	output wire        scl_oe_n,          // SCL pull-low enable, active low
	input  wire [2:0]  addr_strap,        // Address strap pins
	output reg  [6:0]  i2c_addr,          // Bus address in use
	input  wire        i2c_start,         // Start condition seen, pulse
	input  wire        byte_stb,          // Received byte valid, pulse
	input  wire [7:0]  byte_data,         // Received byte
	input  wire        addr_read,         // Own address with read bit, pulse
	input  wire        reg_read,          // Register read command, pulse
	input  wire        nack_rx,           // Host NACK, pulse
	input  wire        stop_rx,           // Stop condition, pulse
	output reg         conv_start,        // Start one conversion, pulse
	output reg         conv_channel,      // Input to convert
	input  wire        conv_done,         // Conversion finished, pulse
	input  wire [11:0] conv_data,         // Conversion result
	output reg         cal_start,         // Start offset calibration, pulse
	output wire        busy_rdy,          // Conversion pending, active high
	output wire        alert,             // Threshold event
	output wire        irq                // Interrupt, level
);
	// States
	localparam [1:0] ST_CAL  = 2'd0;      // Offset calibration
	localparam [1:0] ST_IDLE = 2'd1;      // Waiting for a start
	localparam [1:0] ST_MAN  = 2'd2;      // Manual stream on SCL
	localparam [1:0] ST_AUTO = 2'd3;      // Oscillator-paced monitoring
	// Mode kinds
	localparam [1:0] K_NONE  = 2'd0;      // Unassigned code
	localparam [1:0] K_ONE   = 2'd1;      // Manual, first input only
	localparam [1:0] K_SCAN  = 2'd2;      // Manual, auto sequence
	localparam [1:0] K_AUTO  = 2'd3;      // Autonomous

	// Decode the three-bit mode select
	function [1:0] fn_kind;
		input [2:0] m;
		begin
			case (m)
				3'h0, 3'h1: fn_kind = K_ONE;    // R10
				3'h4, 3'h5: fn_kind = K_SCAN;   // R12
				3'h6:       fn_kind = K_AUTO;   // R17
				default:    fn_kind = K_NONE;   // R19
			endcase
		end
	endfunction

	// First input of the scan selection
	function fn_first;
		input [1:0] sel;
		begin
			fn_first = ~sel[0] & sel[1];
		end
	endfunction

	wire        scl_s;                    // Synchronised SCL
	wire [2:0]  strap_s;                  // Synchronised strap
	wire        sample_tick;              // Manual sample boundary
	reg  [1:0]  state_reg;                // Sequencer state
	reg  [2:0]  mode_reg;                 // operating_mode_select
	reg  [7:0]  key_reg;                  // reset_unlock_key
	reg  [1:0]  chsel_reg;                // scan_channel_select
	reg  [7:0]  space_reg;                // cycle_spacing_count
	reg  [11:0] hi_lim_reg;               // High limit
	reg  [11:0] lo_lim_reg;               // Low limit
	reg  [3:0]  stat_reg;                 // Sticky event bits
	reg  [3:0]  mask_reg;                 // Interrupt mask
	reg  [11:0] data_reg;                 // Last result
	reg         data_ch_reg;              // Input of last result
	reg         armed_reg;                // scan_go_bit seen
	reg         nack_seen_reg;            // NACK before STOP
	reg         pend_reg;                 // Conversion in flight
	reg         eval_addr_reg;            // Address to be reread
	reg  [7:0]  cal_cnt_reg;              // Calibration timer
	reg  [6:0]  osc_cnt_reg;              // Internal oscillator divider
	reg  [7:0]  gap_cnt_reg;              // Oscillator periods since start
	reg         first_byte_reg;           // Next byte is first after start
	reg         gc_armed_reg;             // General call byte received

	wire wr_en    = psel & penable & pwrite;
	wire wr_ctrl  = wr_en & (paddr == `ADCMS_CTRL_OFS);
	wire [1:0] kind = fn_kind(mode_reg);
	wire [1:0] go_kind = fn_kind(pwdata[`ADCMS_MODE_MSB:0]); // Mode written with go
	wire gc_hit   = byte_stb & gc_armed_reg & (byte_data == `ADCMS_SRST_BYTE);
	wire full_rst = ~rstn | gc_hit;                                        // R3
	wire soft_hit = wr_ctrl & pwdata[`ADCMS_SRST_BIT] & (key_reg == `ADCMS_KEY_VAL); // R5
	wire cfg_rst  = full_rst | soft_hit;
	wire go_wr    = wr_ctrl & pwdata[`ADCMS_GO_BIT];
	wire halt_wr  = wr_ctrl & pwdata[`ADCMS_HALT_BIT];
	wire cal_wr   = wr_ctrl & pwdata[`ADCMS_CAL_BIT];
	wire osc_tick = ({25'h0, osc_cnt_reg} == `ADCMS_OSC_CYC - 1);
	wire gap_end  = osc_tick & (gap_cnt_reg + 8'd1 >= space_reg);
	wire cal_end  = (state_reg == ST_CAL) & ({24'h0, cal_cnt_reg} == `ADCMS_CAL_CYC - 1);
	wire hi_cross = (state_reg == ST_AUTO) & conv_done & (conv_data > hi_lim_reg);
	wire lo_cross = (state_reg == ST_AUTO) & conv_done & (conv_data < lo_lim_reg);
	// Events that end a stream
	wire stop_one = (kind == K_ONE) & nack_seen_reg & stop_rx;             // R11
	wire stop_scn = (kind != K_ONE) & (halt_wr | reg_read);                // R13 R14
	wire run_end  = ((state_reg == ST_MAN) | (state_reg == ST_AUTO)) & (stop_one | stop_scn);
	wire man_go   = (state_reg == ST_IDLE) & addr_read &
	                (kind == K_ONE | (kind == K_SCAN & armed_reg));        // R10 R12
	wire auto_go  = (state_reg == ST_IDLE) & (go_kind == K_AUTO) & go_wr;  // R17
	wire conv_req = ((state_reg == ST_MAN) & sample_tick) |
	                ((state_reg == ST_AUTO) & gap_end) | auto_go;

	assign pready   = 1'b1;
	assign busy_rdy = (state_reg == ST_CAL) | pend_reg;                    // R2
	assign alert    = stat_reg[`ADCMS_IRQ_HIGH] | stat_reg[`ADCMS_IRQ_LOW]; // R18
	assign irq      = |(stat_reg & mask_reg);

	// SCL pin and strap come from outside the clock domain
	adcms_sync #(
		.W (4)
	) u_sync (
		.ref_clk (ref_clk),
		.d       ({scl_in, addr_strap}),
		.q       ({scl_s, strap_s})
	);

	// SCL pacing and stretching for manual streams
	adcms_scl_pace u_pace (
		.ref_clk     (ref_clk),
		.rstn        (rstn),
		.run         (state_reg == ST_MAN),
		.scl_s       (scl_s),
		.sample_tick (sample_tick),
		.scl_oe_n    (scl_oe_n)
	);

	// General call detector, cleared only by the pin reset
	always @(posedge ref_clk) begin
		if (!rstn) begin
			first_byte_reg <= 1'b0;
			gc_armed_reg   <= 1'b0;
		end else if (i2c_start) begin
			first_byte_reg <= 1'b1;
			gc_armed_reg   <= 1'b0;
		end else if (byte_stb) begin
			first_byte_reg <= 1'b0;
			gc_armed_reg   <= first_byte_reg & (byte_data == `ADCMS_GCALL_BYTE); // R3
		end
	end

	// Key register survives the soft reset
	always @(posedge ref_clk) begin
		if (full_rst)
			key_reg <= 8'h00;                                              // R4
		else if (wr_en & (paddr == `ADCMS_KEY_OFS))
			key_reg <= pwdata[7:0];                                        // R5
	end

	// Configuration registers, cleared by every reset path
	always @(posedge ref_clk) begin
		if (cfg_rst) begin
			mode_reg   <= `ADCMS_MODE_RST;                                 // R1
			chsel_reg  <= `ADCMS_CHSEL_RST;                                // R8
			space_reg  <= `ADCMS_SPACE_RST;
			hi_lim_reg <= `ADCMS_HI_RST;
			lo_lim_reg <= `ADCMS_LO_RST;
			mask_reg   <= 4'h0;
		end else if (wr_en) begin
			case (paddr)
				`ADCMS_CTRL_OFS:  mode_reg   <= pwdata[`ADCMS_MODE_MSB:0]; // R1
				`ADCMS_CHSEL_OFS: chsel_reg  <= pwdata[1:0];
				`ADCMS_SPACE_OFS: space_reg  <= pwdata[7:0];
				`ADCMS_LIMIT_OFS: begin
					lo_lim_reg <= pwdata[11:0];
					hi_lim_reg <= pwdata[`ADCMS_HI_LSB+11:`ADCMS_HI_LSB];
				end
				`ADCMS_IRQM_OFS:  mask_reg   <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	// Sticky status; hardware set wins over write-one clear
	always @(posedge ref_clk) begin
		if (full_rst) begin
			stat_reg <= 4'h0;
		end else begin
			if (soft_hit) begin
				// Latched window flags survive the soft reset
				stat_reg[`ADCMS_IRQ_DONE] <= 1'b0;                         // R5
				stat_reg[`ADCMS_IRQ_END]  <= 1'b0;
			end else if (wr_en & (paddr == `ADCMS_IRQS_OFS)) begin
				stat_reg <= stat_reg & ~pwdata[3:0];
			end
			if (conv_done)
				stat_reg[`ADCMS_IRQ_DONE] <= 1'b1;
			if (hi_cross)
				stat_reg[`ADCMS_IRQ_HIGH] <= 1'b1;                         // R18
			if (lo_cross)
				stat_reg[`ADCMS_IRQ_LOW]  <= 1'b1;                         // R18
			if (run_end)
				stat_reg[`ADCMS_IRQ_END]  <= 1'b1;
		end
	end

	// Sequencer
	always @(posedge ref_clk) begin
		cal_start <= 1'b0;
		if (full_rst) begin
			state_reg     <= ST_CAL;                                       // R2 R4
			cal_cnt_reg   <= 8'h00;
			eval_addr_reg <= 1'b1;                                         // R4
			armed_reg     <= 1'b0;
			nack_seen_reg <= 1'b0;
		end else if (soft_hit) begin
			state_reg     <= ST_IDLE;                                      // R6
			armed_reg     <= 1'b0;
			nack_seen_reg <= 1'b0;
		end else if (cal_wr & (state_reg != ST_CAL)) begin
			// Calibration on demand abandons any stream
			state_reg     <= ST_CAL;                                       // R7
			cal_cnt_reg   <= 8'h00;
			armed_reg     <= 1'b0;
		end else begin
			case (state_reg)
				ST_CAL: begin
					cal_start   <= (cal_cnt_reg == 8'h00); // R2 R7
					cal_cnt_reg <= cal_cnt_reg + 8'd1;
					if (cal_end) begin
						state_reg     <= ST_IDLE;
						eval_addr_reg <= 1'b0;
					end
				end
				ST_IDLE: begin
					nack_seen_reg <= 1'b0;
					if (go_wr & (go_kind == K_SCAN))
						armed_reg <= 1'b1;                                 // R12
					if (man_go)
						state_reg <= ST_MAN;
					else if (auto_go)
						state_reg <= ST_AUTO;                              // R17
				end
				ST_MAN, ST_AUTO: begin
					if (nack_rx)
						nack_seen_reg <= 1'b1;
					else if (i2c_start)
						nack_seen_reg <= 1'b0;
					if (run_end) begin
						state_reg <= ST_IDLE;
						armed_reg <= 1'b0;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Address is reread from the strap only after a full reset
	always @(posedge ref_clk) begin
		if (!rstn)
			i2c_addr <= {`ADCMS_ADDR_BASE, 3'h0};
		else if (cal_end & eval_addr_reg)
			i2c_addr <= {`ADCMS_ADDR_BASE, strap_s};                       // R2 R6
	end

	// Internal oscillator and spacing count, used only when autonomous
	always @(posedge ref_clk) begin
		if (!rstn || state_reg != ST_AUTO) begin
			osc_cnt_reg <= 7'h00;
			gap_cnt_reg <= 8'h00;
		end else begin
			osc_cnt_reg <= osc_tick ? 7'h00 : osc_cnt_reg + 7'd1;
			if (gap_end)
				gap_cnt_reg <= 8'h00;                                      // R17
			else if (osc_tick)
				gap_cnt_reg <= gap_cnt_reg + 8'd1;
		end
	end

	// Conversion start and input selection
	always @(posedge ref_clk) begin
		if (cfg_rst) begin
			conv_start   <= 1'b0;
			conv_channel <= 1'b0;                                          // R8
			pend_reg     <= 1'b0;
		end else begin
			conv_start <= conv_req;                                        // R9 R16
			if (conv_req)
				pend_reg <= 1'b1;
			else if (conv_done)
				pend_reg <= 1'b0;
			if (man_go | auto_go) begin
				// First sample of a stream
				conv_channel <= (man_go & (kind == K_ONE)) ? 1'b0 : fn_first(chsel_reg); // R10
			end else if (conv_start & (kind != K_ONE) & (chsel_reg == 2'h3)) begin
				// Alternate after each issued conversion
				conv_channel <= ~conv_channel;                             // R15
			end
		end
	end

	// Last result capture
	always @(posedge ref_clk) begin
		if (cfg_rst) begin
			data_reg    <= 12'h000;
			data_ch_reg <= 1'b0;
		end else if (conv_done) begin
			data_reg    <= conv_data;
			data_ch_reg <= conv_channel;
		end
	end

	// APB read data captured in the setup phase, valid in the access phase
	always @(posedge ref_clk) begin
		if (!rstn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel & ~penable) begin
			pslverr <= 1'b0;
			case (paddr)
				`ADCMS_CTRL_OFS:  prdata <= {29'h0, mode_reg};
				`ADCMS_KEY_OFS:   prdata <= {24'h0, key_reg};
				`ADCMS_CHSEL_OFS: prdata <= {30'h0, chsel_reg};
				`ADCMS_SPACE_OFS: prdata <= {24'h0, space_reg};
				`ADCMS_LIMIT_OFS: prdata <= {4'h0, hi_lim_reg, 4'h0, lo_lim_reg};
				`ADCMS_STAT_OFS:  prdata <= {16'h0, 1'b0, i2c_addr, 1'b0, eval_addr_reg,
				                             pend_reg, armed_reg, conv_channel, 1'b0, state_reg};
				`ADCMS_IRQS_OFS:  prdata <= {28'h0, stat_reg};
				`ADCMS_IRQM_OFS:  prdata <= {28'h0, mask_reg};
				`ADCMS_DATA_OFS:  prdata <= {15'h0, data_ch_reg, 4'h0, data_reg};
				default: begin
					prdata  <= 32'h0000_0000;
					pslverr <= 1'b1;
				end
			endcase
		end
	end
endmodule // adcms_top
`default_nettype wire

// file: tb/adcms_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "adcms_defs.vh"
// Pin-level timing checks on the sequencer
module adcms_props (
	input wire logic       ref_clk,    // Block clock
	input wire logic       rstn,       // Synchronous reset, active low
	input wire logic       scl_oe_n,   // Stretch enable, active low
	input wire logic [2:0] addr_strap, // Strap pins
	input wire logic [6:0] i2c_addr,   // Address in use
	input wire logic       byte_stb,   // Byte valid
	input wire logic [7:0] byte_data,  // Byte value
	input wire logic       conv_start, // Conversion start
	input wire logic       cal_start,  // Calibration start
	input wire logic       busy_rdy    // Pending output
);
	logic [8:0] str_cnt_reg; // Length of the running stretch, saturates
	// Counter rather than repetition: a stretch runs far past 8 cycles
	always_ff @(posedge ref_clk) str_cnt_reg <= (!rstn || scl_oe_n) ? 9'h000 : str_cnt_reg + {8'h00, str_cnt_reg != 9'h1FF};
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// General call followed by the reset byte
	sequence s_gc;
		byte_stb && byte_data == `ADCMS_GCALL_BYTE ##[1:20] byte_stb && byte_data == `ADCMS_SRST_BYTE;
	endsequence
	sequence s_busy_run;
		busy_rdy [*8];
	endsequence
	property p_gc; s_gc |-> ##[1:4] cal_start; endproperty
	a_gc: assert property (p_gc) else $error("no calibration after general call reset");
	property p_cal_busy; cal_start |=> s_busy_run; endproperty
	a_cal_busy: assert property (p_cal_busy) else $error("pending low during calibration");
	property p_cal_pulse; cal_start |=> !cal_start [*8]; endproperty
	a_cal_pulse: assert property (p_cal_pulse) else $error("calibration restarted at once");
	property p_conv_pend; conv_start |-> busy_rdy; endproperty
	a_conv_pend: assert property (p_conv_pend) else $error("pending low at conversion start");
	property p_conv_gap; conv_start |=> !conv_start [*8]; endproperty
	a_conv_gap: assert property (p_conv_gap) else $error("conversion starts too close");
	property p_str_min; $fell(scl_oe_n) |-> !scl_oe_n [*8]; endproperty
	a_str_min: assert property (p_str_min) else $error("stretch too short");
	property p_str_max; str_cnt_reg <= 9'h0BE; endproperty
	a_str_max: assert property (p_str_max) else $error("stretch too long");
	property p_addr; !$stable(i2c_addr) && i2c_addr != 7'h08 |-> i2c_addr == {`ADCMS_ADDR_BASE, $past(addr_strap, 4)}; endproperty
	a_addr: assert property (p_addr) else $error("address does not follow strap");
endmodule // adcms_props
`default_nettype wire

// file: tb/adcms_host.sv
`timescale 1ns/100ps
`default_nettype none
// Bus host stand-in: drives SCL and the decoded bus events
module adcms_host (
	input  wire logic       ref_clk,   // Block clock
	input  wire logic       scl_oe_n,  // Device stretch, active low
	output wire logic       scl_in,    // Wired SCL level
	output wire logic       i2c_start, // Start seen
	output wire logic       byte_stb,  // Byte valid
	output var  logic [7:0] byte_data, // Byte value
	output wire logic       addr_read, // Own address, read
	output wire logic       reg_read,  // Register read command
	output wire logic       nack_rx,   // Host NACK
	output wire logic       stop_rx    // Stop condition
);
	logic       host_scl; // SCL stands high outside frames
	logic [5:0] ev;       // Event pulses
	// Open drain: the device wins when it pulls low
	assign scl_in = host_scl & scl_oe_n;
	assign {i2c_start, byte_stb, addr_read, reg_read, nack_rx, stop_rx} = ev;
	initial {host_scl, ev, byte_data} = {1'b1, 6'h00, 8'h00};
	// One-cycle event pulse
	task pulse(input logic [5:0] m);
		@(posedge ref_clk);
		ev <= m;
		@(posedge ref_clk);
		ev <= 6'h00;
	endtask
	// Received byte with its strobe
	task put(input logic [7:0] b);
		@(posedge ref_clk);
		byte_data <= b;
		pulse(6'h10);
	endtask
	// SCL periods with a given low time; waits out any stretch
	task clocks(input int n, input int lo);
		int j;
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			host_scl <= 1'b0;
			repeat (lo) @(posedge ref_clk);
			host_scl <= 1'b1;
			j = 0;
			while (scl_in !== 1'b1 && j < 400) begin
				@(posedge ref_clk);
				j++;
			end
			repeat (3) @(posedge ref_clk);
		end
	endtask
endmodule // adcms_host
`default_nettype wire

// file: tb/adc_mode_sequencer_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "adcms_defs.vh"
module adc_mode_sequencer_bench;
	logic        ref_clk    = 1'b0;   // 100 MHz
	logic        rstn       = 1'b0;   // Reset, active low
	logic        psel       = 1'b0;   // APB select
	logic        penable    = 1'b0;   // APB enable
	logic        pwrite     = 1'b0;   // APB direction
	logic [7:0]  paddr      = 8'h00;  // APB address
	logic [31:0] pwdata     = 32'h0;  // APB write data
	logic [2:0]  addr_strap = 3'h5;   // Strap pins
	logic        conv_done  = 1'b0;   // Converter finished
	logic [11:0] conv_data  = 12'h0;  // Converter result
	logic [11:0] conv_val   = 12'h123; // Next converter answer
	wire logic [31:0] prdata;
	wire logic [6:0]  i2c_addr;
	wire logic [7:0]  byte_data;
	wire logic pready, pslverr, scl_oe_n, scl_in, i2c_start, byte_stb, addr_read, reg_read;
	wire logic nack_rx, stop_rx, conv_start, conv_channel, cal_start, busy_rdy, alert, irq;
	int failures = 0;
	int checks = 0;
	int conv_n = 0;         // Conversions started
	int cal_n = 0;          // Calibrations started
	int n0;
	bit str;                // Stretch seen
	logic [31:0] d, last_data;
	logic e;
	logic chans[$];         // Channel of each conversion
	adcms_top adcms_top_inst (.*);
	adcms_host adcms_host_inst (.*);
	initial forever #5 ref_clk = ~ref_clk;
	// Converter stand-in answers one cycle after each start
	always @(posedge ref_clk) begin
		conv_done <= 1'b0;
		if (conv_start === 1'b1) begin
			conv_done <= 1'b1;
			conv_data <= conv_val;
			last_data = {15'h0, conv_channel, 4'h0, conv_val};
			chans.push_back(conv_channel);
			conv_n++;
		end
		if (cal_start === 1'b1) cal_n++;
		if (adcms_host_inst.host_scl === 1'b1 && scl_in === 1'b0) str = 1'b1;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer; data and error taken where pready is seen
	task apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge ref_clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		psel <= 1'b1;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task settle;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
	// Bounded wait for calibration to end
	task wait_idle;
		int j;
		j = 0;
		repeat (3) @(posedge ref_clk);
		while (busy_rdy !== 1'b0 && j < 1000) begin
			@(posedge ref_clk);
			j++;
		end
		#1;
	endtask
	// Read frame, optional extra event, then SCL periods
	task frame(input int n, input int lo, input logic [5:0] ex);
		str = 1'b0;
		adcms_host_inst.pulse(6'h08);
		if (ex != 6'h00) adcms_host_inst.pulse(ex);
		n0 = conv_n;
		adcms_host_inst.clocks(n, lo);
		settle;
	endtask
	task close_out;
		if (failures == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog, some seven times the run of about 8k cycles
	initial begin
		repeat (60000) @(posedge ref_clk);
		failures++;
		close_out;
	end
	initial begin
		void'($urandom(32'h2016));
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		wait_idle;
		chk(cal_n, 1);
		chk(i2c_addr, {`ADCMS_ADDR_BASE, 3'h5});
		apb(`ADCMS_CTRL_OFS, 1'b0, 32'h0);
		chk(d[2:0], `ADCMS_MODE_RST);
		apb(`ADCMS_CHSEL_OFS, 1'b0, 32'h0);
		chk(d, 32'h1);
		apb(8'h40, 1'b0, 32'h0);
		chk(e, 1'b1);
		// Every mode code with a bare read frame
		for (int m = 0; m < 8; m++) begin
			conv_val = 12'(32'h100 + $urandom % 32'hD00);
			apb(`ADCMS_SPACE_OFS, 1'b1, 32'h1 + $urandom % 32'hFE);
			apb(`ADCMS_CTRL_OFS, 1'b1, m);
			frame(18, 4, 6'h00);
			chk(conv_n - n0, m < 2);
			if (m < 2) begin
				chk(chans[$], 1'b0);
				chk(str, 1'b1);
				apb(`ADCMS_DATA_OFS, 1'b0, 32'h0);
				chk(d, last_data);
			end
			adcms_host_inst.pulse(6'h02);
			adcms_host_inst.pulse(6'h01);
		end
		apb(`ADCMS_CTRL_OFS, 1'b1, 32'h0);
		frame(18, 185, 6'h00);
		chk(conv_n - n0, 1);
		chk(str, 1'b0);
		adcms_host_inst.pulse(6'h02);
		adcms_host_inst.pulse(6'h01);
		apb(`ADCMS_CHSEL_OFS, 1'b1, 32'h3);
		apb(`ADCMS_CTRL_OFS, 1'b1, 32'h0C);
		frame(54, 4, 6'h00);
		chk(conv_n - n0, 3);
		chk({chans[$-2], chans[$-1], chans[$]}, 3'h2);
		apb(`ADCMS_CTRL_OFS, 1'b1, 32'h14);
		frame(18, 4, 6'h00);
		chk(conv_n - n0, 0);
		apb(`ADCMS_CTRL_OFS, 1'b1, 32'h0D);
		frame(18, 4, 6'h04);
		chk(conv_n - n0, 0);
		apb(`ADCMS_LIMIT_OFS, 1'b1, 32'h0E000100);
		apb(`ADCMS_IRQM_OFS, 1'b1, 32'h6);
		apb(`ADCMS_SPACE_OFS, 1'b1, 32'h1);
		conv_val = 12'h800;
		n0 = conv_n;
		apb(`ADCMS_CTRL_OFS, 1'b1, 32'h0E);
		repeat (250) @(posedge ref_clk);
		#1;
		chk(conv_n - n0, 3);
		chk(alert, 1'b0);
		conv_val = 12'hF00;
		repeat (100) @(posedge ref_clk);
		#1;
		chk(alert, 1'b1);
		chk(irq, 1'b1);
		apb(`ADCMS_IRQS_OFS, 1'b0, 32'h0);
		chk(d[1], 1'b1);
		apb(`ADCMS_IRQM_OFS, 1'b1, 32'h0);
		settle;
		chk(irq, 1'b0);
		apb(`ADCMS_CTRL_OFS, 1'b1, 32'h16);
		n0 = cal_n;
		apb(`ADCMS_KEY_OFS, 1'b1, `ADCMS_KEY_VAL);
		apb(`ADCMS_CTRL_OFS, 1'b1, 32'h40);
		settle;
		chk(cal_n - n0, 0);
		chk(alert, 1'b1);
		chk(i2c_addr, {`ADCMS_ADDR_BASE, 3'h5});
		apb(`ADCMS_LIMIT_OFS, 1'b0, 32'h0);
		chk(d, 32'h0FFF0000);
		apb(`ADCMS_KEY_OFS, 1'b0, 32'h0);
		chk(d[7:0], `ADCMS_KEY_VAL);
		apb(`ADCMS_IRQS_OFS, 1'b1, 32'hF);
		settle;
		chk(alert, 1'b0);
		apb(`ADCMS_CTRL_OFS, 1'b1, 32'h20);
		wait_idle;
		chk(cal_n - n0, 1);
		addr_strap <= 3'h2;
		apb(`ADCMS_CTRL_OFS, 1'b1, 32'h1);
		adcms_host_inst.pulse(6'h20);
		adcms_host_inst.put(`ADCMS_GCALL_BYTE);
		adcms_host_inst.put(`ADCMS_SRST_BYTE);
		wait_idle;
		chk(cal_n - n0, 2);
		chk(i2c_addr, {`ADCMS_ADDR_BASE, 3'h2});
		apb(`ADCMS_CTRL_OFS, 1'b0, 32'h0);
		chk(d[2:0], `ADCMS_MODE_RST);
		close_out;
	end
endmodule // adc_mode_sequencer_bench
bind adcms_top adcms_props adcms_props_inst (.*);
`default_nettype wire
